// [logic/uart_device.sv]
module uart_device (
  // clock, reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic master_reset_i,
  // link
  uart_if.dev link,
  output logic serial_tx_out_o,
  // transmit side
  input wire logic [7:0] tx_char_in_i,
  input wire logic tx_buffer_load_n_i,
  output logic tx_buffer_empty_o,
  output logic tx_buffer_empty_oe_n_o,
  output logic tx_shift_empty_o,
  // format
  input wire logic format_word_load_i,
  input wire logic [4:0] format_i,
  // receive side
  output logic [7:0] rx_char_out_o,
  output logic rx_char_out_oe_n_o,
  input wire logic rx_output_disable_i,
  input wire logic rx_flag_clear_n_i,
  output logic rx_char_ready_o,
  output logic parity_error_flag_o,
  output logic framing_error_flag_o,
  output logic overrun_flag_o,
  output logic status_oe_n_o,
  input wire logic status_out_disable_i
);
  logic [4:0] fmt_ff;
  logic [7:0] tbuf_ff, rbuf_ff, tsh_ff, rsh_ff;
  logic tbe_ff, tload_d_ff, treq_ff, tre_ff, txo_ff;
  logic [4:0] tre_cnt_ff;
  logic tck_d_ff, rck_d_ff, rxi_d_ff;
  logic [4:0] tsub_ff, rsub_ff;
  logic [2:0] tbit_ff, rbit_ff;
  logic [1:0] tstop_ff;
  logic tpar_ff, rpar_ff;
  uart_pkg::ser_state_type tst_ff, rst_ff;
  logic dr_ff, pe_ff, fe_ff, oe_ff, drr_seen_ff;
  logic roe_ff, soe_ff;
  logic tick_t, tick_r, tx_free;
  logic [2:0] last_bit;
  logic [7:0] tmask;
  assign tick_t = link.tx_clock_16x && !tck_d_ff;
  assign tick_r = link.rx_clock_16x && !rck_d_ff;
  assign last_bit = {1'b1, fmt_ff[uart_pkg::FMT_LEN_HI],
    fmt_ff[uart_pkg::FMT_LEN_LO]};
  assign tmask = 8'hff >> (3'h7 - last_bit);
  // shifter can take a new character: idle or at the last stop tick
  assign tx_free = tst_ff == uart_pkg::ST_IDLE ||
    (tst_ff == uart_pkg::ST_STOP && tstop_ff == 2'h0 &&
     tsub_ff == uart_pkg::OVS - 5'h01);
  assign serial_tx_out_o = txo_ff;
  assign tx_buffer_empty_o = tbe_ff;
  assign tx_shift_empty_o = tre_ff;
  assign rx_char_out_o = rbuf_ff;
  assign rx_char_out_oe_n_o = roe_ff;
  assign rx_char_ready_o = dr_ff;
  assign parity_error_flag_o = pe_ff;
  assign framing_error_flag_o = fe_ff;
  assign overrun_flag_o = oe_ff;
  assign status_oe_n_o = soe_ff;
  assign tx_buffer_empty_oe_n_o = soe_ff;
  // output enables
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      roe_ff <= 1'b1;
      soe_ff <= 1'b1;
    end else if (ce_i) begin
      roe_ff <= rx_output_disable_i;
      soe_ff <= status_out_disable_i;
    end
  end
  // format word and edge samplers
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fmt_ff <= uart_pkg::FMT_RESET;
      tck_d_ff <= 1'b0;
      rck_d_ff <= 1'b0;
      rxi_d_ff <= 1'b1;
      tload_d_ff <= 1'b1;
    end else if (ce_i) begin
      if (format_word_load_i) begin
        fmt_ff <= format_i;
      end
      tck_d_ff <= link.tx_clock_16x;
      rck_d_ff <= link.rx_clock_16x;
      if (tick_r) begin
        rxi_d_ff <= link.serial_line;
      end
      tload_d_ff <= tx_buffer_load_n_i;
    end
  end
  // transmit buffer
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tbuf_ff <= 8'h00;
      tbe_ff <= 1'b1;
      treq_ff <= 1'b0;
    end else if (ce_i) begin
      if (master_reset_i) begin
        tbe_ff <= 1'b1;
        treq_ff <= 1'b0;
      end else begin
        if (!tx_buffer_load_n_i) begin
          tbuf_ff <= tx_char_in_i & tmask;
          tbe_ff <= 1'b0;
        end
        if (tx_buffer_load_n_i && !tload_d_ff) begin
          treq_ff <= 1'b1;
        end else if (treq_ff && tx_free && tick_t) begin
          treq_ff <= 1'b0;
          tbe_ff <= 1'b1;
        end
      end
    end
  end
  // transmit shifter
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tst_ff <= uart_pkg::ST_IDLE;
      tsh_ff <= 8'h00;
      txo_ff <= 1'b1;
      tsub_ff <= 5'h00;
      tbit_ff <= 3'h0;
      tstop_ff <= 2'h0;
      tpar_ff <= 1'b0;
    end else if (ce_i) begin
      if (master_reset_i) begin
        tst_ff <= uart_pkg::ST_IDLE;
        txo_ff <= 1'b1;
      end else if (tick_t) begin
        case (tst_ff)
          uart_pkg::ST_IDLE: begin
            if (treq_ff) begin
              tsh_ff <= tbuf_ff;
              tpar_ff <= ^tbuf_ff ^ !fmt_ff[uart_pkg::FMT_EVEN];
              txo_ff <= 1'b0;
              tsub_ff <= 5'h00;
              tst_ff <= uart_pkg::ST_START;
            end
          end
          default: begin
            if (tsub_ff == uart_pkg::OVS - 5'h01 ||
                (tst_ff == uart_pkg::ST_STOP && tstop_ff == 2'h1 &&
                 last_bit == 3'h4 && tsub_ff == uart_pkg::HALF_STOP - 5'h01)) begin
              tsub_ff <= 5'h00;
              case (tst_ff)
                uart_pkg::ST_START: begin
                  txo_ff <= tsh_ff[0];
                  tbit_ff <= 3'h0;
                  tst_ff <= uart_pkg::ST_DATA;
                end
                uart_pkg::ST_DATA: begin
                  if (tbit_ff == last_bit) begin
                    if (!fmt_ff[uart_pkg::FMT_POFF]) begin
                      txo_ff <= tpar_ff;
                      tst_ff <= uart_pkg::ST_PAR;
                    end else begin
                      txo_ff <= 1'b1;
                      tstop_ff <= {1'b0, fmt_ff[uart_pkg::FMT_STOP]};
                      tst_ff <= uart_pkg::ST_STOP;
                    end
                  end else begin
                    tsh_ff <= tsh_ff >> 1;
                    txo_ff <= tsh_ff[1];
                    tbit_ff <= tbit_ff + 3'h1;
                  end
                end
                uart_pkg::ST_PAR: begin
                  txo_ff <= 1'b1;
                  tstop_ff <= {1'b0, fmt_ff[uart_pkg::FMT_STOP]};
                  tst_ff <= uart_pkg::ST_STOP;
                end
                uart_pkg::ST_STOP: begin
                  if (tstop_ff == 2'h0 && treq_ff) begin
                    tsh_ff <= tbuf_ff;
                    tpar_ff <= ^tbuf_ff ^ !fmt_ff[uart_pkg::FMT_EVEN];
                    txo_ff <= 1'b0;
                    tst_ff <= uart_pkg::ST_START;
                  end else if (tstop_ff == 2'h0) begin
                    tst_ff <= uart_pkg::ST_IDLE;
                  end else begin
                    tstop_ff <= tstop_ff - 2'h1;
                  end
                end
                default: tst_ff <= uart_pkg::ST_IDLE;
              endcase
            end else begin
              tsub_ff <= tsub_ff + 5'h01;
            end
          end
        endcase
      end
    end
  end
  // transmitter empty flag
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tre_ff <= 1'b0;
      tre_cnt_ff <= 5'h00;
    end else if (ce_i) begin
      if (master_reset_i) begin
        tre_ff <= 1'b0;
        tre_cnt_ff <= uart_pkg::TRE_DELAY;
      end else if (tre_cnt_ff != 5'h00) begin
        tre_cnt_ff <= tre_cnt_ff - 5'h01;
        tre_ff <= tre_cnt_ff == 5'h01;
      end else begin
        tre_ff <= tst_ff == uart_pkg::ST_IDLE && !treq_ff;
      end
    end
  end
  // receiver
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_ff <= uart_pkg::ST_IDLE;
      rsh_ff <= 8'h00;
      rbuf_ff <= 8'h00;
      rsub_ff <= 5'h00;
      rbit_ff <= 3'h0;
      rpar_ff <= 1'b0;
      dr_ff <= 1'b0;
      pe_ff <= 1'b0;
      fe_ff <= 1'b0;
      oe_ff <= 1'b0;
      drr_seen_ff <= 1'b0;
    end else if (ce_i) begin
      if (master_reset_i) begin
        dr_ff <= 1'b0;
        pe_ff <= 1'b0;
        fe_ff <= 1'b0;
        oe_ff <= 1'b0;
        rst_ff <= uart_pkg::ST_IDLE;
      end else begin
        if (!rx_flag_clear_n_i) begin
          dr_ff <= 1'b0;
          drr_seen_ff <= 1'b1;
        end
        if (fmt_ff[uart_pkg::FMT_POFF]) begin
          pe_ff <= 1'b0;
        end
        if (tick_r) begin
          case (rst_ff)
            uart_pkg::ST_IDLE: begin
              if (rxi_d_ff && !link.serial_line) begin
                rsub_ff <= 5'h00;
                rst_ff <= uart_pkg::ST_START;
              end
            end
            uart_pkg::ST_START: begin
              if (rsub_ff == uart_pkg::HALF - 5'h01) begin
                rsub_ff <= 5'h00;
                rbit_ff <= 3'h0;
                rsh_ff <= 8'h00;
                rst_ff <= link.serial_line ? uart_pkg::ST_IDLE
                  : uart_pkg::ST_DATA;
              end else begin
                rsub_ff <= rsub_ff + 5'h01;
              end
            end
            default: begin
              if (rsub_ff == uart_pkg::OVS - 5'h01) begin
                rsub_ff <= 5'h00;
                case (rst_ff)
                  uart_pkg::ST_DATA: begin
                    rsh_ff[rbit_ff] <= link.serial_line;
                    rbit_ff <= rbit_ff + 3'h1;
                    if (rbit_ff == last_bit) begin
                      rst_ff <= fmt_ff[uart_pkg::FMT_POFF] ?
                        uart_pkg::ST_STOP : uart_pkg::ST_PAR;
                    end
                  end
                  uart_pkg::ST_PAR: begin
                    rpar_ff <= link.serial_line;
                    rst_ff <= uart_pkg::ST_STOP;
                  end
                  uart_pkg::ST_STOP: begin
                    rbuf_ff <= rsh_ff;
                    dr_ff <= 1'b1;
                    oe_ff <= dr_ff ? 1'b1 : (drr_seen_ff ? 1'b0 : oe_ff);
                    drr_seen_ff <= 1'b0;
                    fe_ff <= !link.serial_line;
                    pe_ff <= !fmt_ff[uart_pkg::FMT_POFF] &&
                      ((^rsh_ff ^ rpar_ff) == fmt_ff[uart_pkg::FMT_EVEN]);
                    rst_ff <= uart_pkg::ST_IDLE;
                  end
                  default: rst_ff <= uart_pkg::ST_IDLE;
                endcase
              end else begin
                rsub_ff <= rsub_ff + 5'h01;
              end
            end
          endcase
        end
      end
    end
  end
endmodule // uart_device

// [logic/uart_fifo.sv]
module uart_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic en_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wp_ff, rp_ff;
  logic [AW:0] cnt_ff;
  logic push, pop;
  assign in_ready_o = cnt_ff != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_ff != '0;
  assign out_data_o = mem_ff[rp_ff];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_ff @(posedge mclk_i) begin
    if (en_i && push) begin
      mem_ff[wp_ff] <= in_data_i;
    end
  end
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else if (en_i) begin
      if (push) begin
        wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // uart_fifo

// [logic/uart_host.sv]
module uart_host (
  // clock, reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // user side
  input wire logic [7:0] user_data_i,
  input wire logic user_valid_i,
  output logic user_ready_o,
  input wire logic [4:0] user_format_i,
  input wire logic user_format_go_i,
  input wire logic [7:0] baud_div_i,
  // device pins
  uart_if.far link,
  input wire logic tx_buffer_empty_i,
  output logic [7:0] tx_char_in_o,
  output logic tx_buffer_load_n_o,
  output logic format_word_load_o,
  output logic [4:0] format_o
);
  logic [7:0] f_data;
  logic f_valid, f_pop;
  logic [7:0] div_ff;
  logic clk16_ff, load_n_ff, fl_ff, busy_ff, wait_ff;
  logic [7:0] data_ff;
  logic [4:0] fmt_ff;
  uart_fifo #(.WIDTH(8), .DEPTH(uart_pkg::FIFO_DEPTH)) uart_fifo_i (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .en_i(ce_i),
    .in_data_i(user_data_i),
    .in_valid_i(user_valid_i),
    .in_ready_o(user_ready_o),
    .out_data_o(f_data),
    .out_valid_o(f_valid),
    .out_ready_i(f_pop)
  );
  assign f_pop = f_valid && !busy_ff && !wait_ff && tx_buffer_empty_i;
  assign link.tx_clock_16x = clk16_ff;
  assign link.rx_clock_16x = clk16_ff;
  assign link.serial_line = 1'b1;
  assign tx_char_in_o = data_ff;
  assign tx_buffer_load_n_o = load_n_ff;
  assign format_word_load_o = fl_ff;
  assign format_o = fmt_ff;
  // 16x clock divider
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_ff <= 8'h00;
      clk16_ff <= 1'b0;
    end else if (ce_i) begin
      if (div_ff >= baud_div_i) begin
        div_ff <= 8'h00;
        clk16_ff <= !clk16_ff;
      end else begin
        div_ff <= div_ff + 8'h01;
      end
    end
  end
  // load strobes
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      load_n_ff <= 1'b1;
      fl_ff <= 1'b0;
      busy_ff <= 1'b0;
      wait_ff <= 1'b0;
      data_ff <= 8'h00;
      fmt_ff <= uart_pkg::FMT_RESET;
    end else if (ce_i) begin
      fl_ff <= user_format_go_i;
      if (user_format_go_i) begin
        fmt_ff <= user_format_i;
      end
      if (f_pop) begin
        data_ff <= f_data;
        load_n_ff <= 1'b0;
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        load_n_ff <= 1'b1;
        busy_ff <= 1'b0;
        wait_ff <= 1'b1;
      end else if (wait_ff) begin
        wait_ff <= 1'b0;
      end
    end
  end
endmodule // uart_host

// [logic/uart_if.sv]
interface uart_if;
  logic serial_line;
  logic tx_clock_16x;
  logic rx_clock_16x;
  modport dev (input serial_line, input tx_clock_16x, input rx_clock_16x);
  modport far (output serial_line, output tx_clock_16x,
    output rx_clock_16x);
endinterface

// [logic/uart_pkg.sv]
package uart_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FMT_W = 5;
  localparam int unsigned FMT_LEN_LO = 0;
  localparam int unsigned FMT_LEN_HI = 1;
  localparam int unsigned FMT_STOP = 2;
  localparam int unsigned FMT_EVEN = 3;
  localparam int unsigned FMT_POFF = 4;
  localparam logic [FMT_W-1:0] FMT_RESET = 5'h03;
  localparam logic [4:0] OVS = 5'h10;
  localparam logic [4:0] HALF = 5'h08;
  localparam logic [4:0] HALF_STOP = 5'h08;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam logic [4:0] TRE_DELAY = 5'h10;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_START = 3'b001, ST_DATA = 3'b010,
    ST_PAR = 3'b011, ST_STOP = 3'b100
  } ser_state_type;
endpackage

// [testbench/pin_programmed_async_uart_test.sv]
module pin_programmed_async_uart_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic mr = 1'b0, uvalid = 1'b0, ugo = 1'b0, bload = 1'b0;
  logic clr_n = 1'b1, rdis = 1'b0, sdis = 1'b0, flip = 1'b0;
  logic ovx = 1'b0, full = 1'b0;
  logic [7:0] udata = 8'h00, bd = 8'h00, tchar, rx;
  logic [4:0] ufmt = 5'h03, bfmt = 5'h03, fword;
  logic uready, tx_out, tbe, tbe_oe, tx_shift_empty, load_n, fload;
  logic roe, soe, dr, pe, fe, ov, a_roe, a_soe, a_dr, a_pe, a_fe, a_ov;
  logic [4:0] cf [9] = '{5'h04, 5'h09, 5'h16, 5'h07, 5'h0b, 5'h0b,
    5'h0b, 5'h0b, 5'h0b};
  logic [7:0] cd [9] = '{8'hff, 8'hc5, 8'h9a, 8'h3c, 8'ha5, 8'h5a,
    8'he1, 8'he1, 8'h77};
  int cb [9] = '{-1, -1, -1, -1, 9, -1, 10, -1, 9};
  int num_errors = 0, checked = 0;
  time tf = 0, tp = 0;
  uart_if link_a();
  uart_if link_b();

  always #5 mclk_i = ~mclk_i;
  // far-end receiver hears the transmitter, with a bit flipped on demand
  assign link_b.serial_line = tx_out ^ flip;
  assign link_b.tx_clock_16x = link_a.tx_clock_16x;
  assign link_b.rx_clock_16x = link_a.rx_clock_16x;

  uart_host uart_host_i (.mclk_i, .resetn_i, .ce_i(1'b1),
    .user_data_i(udata), .user_valid_i(uvalid), .user_ready_o(uready),
    .user_format_i(ufmt), .user_format_go_i(ugo), .baud_div_i(bd),
    .link(link_a.far), .tx_buffer_empty_i(tbe), .tx_char_in_o(tchar),
    .tx_buffer_load_n_o(load_n), .format_word_load_o(fload),
    .format_o(fword));
  uart_device uart_device_i (.mclk_i, .resetn_i, .ce_i(1'b1),
    .master_reset_i(mr), .link(link_a.dev), .serial_tx_out_o(tx_out),
    .tx_char_in_i(tchar), .tx_buffer_load_n_i(load_n),
    .tx_buffer_empty_o(tbe), .tx_buffer_empty_oe_n_o(tbe_oe),
    .tx_shift_empty_o(tx_shift_empty), .format_word_load_i(fload), .format_i(fword),
    .rx_char_out_o(), .rx_char_out_oe_n_o(a_roe),
    .rx_output_disable_i(rdis), .rx_flag_clear_n_i(clr_n),
    .rx_char_ready_o(a_dr), .parity_error_flag_o(a_pe),
    .framing_error_flag_o(a_fe), .overrun_flag_o(a_ov),
    .status_oe_n_o(a_soe), .status_out_disable_i(sdis));
  uart_device uart_device_b_i (.mclk_i, .resetn_i, .ce_i(1'b1),
    .master_reset_i(mr), .link(link_b.dev), .serial_tx_out_o(),
    .tx_char_in_i(8'h00), .tx_buffer_load_n_i(1'b1),
    .tx_buffer_empty_o(), .tx_buffer_empty_oe_n_o(),
    .tx_shift_empty_o(), .format_word_load_i(bload), .format_i(bfmt),
    .rx_char_out_o(rx), .rx_char_out_oe_n_o(roe),
    .rx_output_disable_i(rdis), .rx_flag_clear_n_i(clr_n),
    .rx_char_ready_o(dr), .parity_error_flag_o(pe),
    .framing_error_flag_o(fe), .overrun_flag_o(ov),
    .status_oe_n_o(soe), .status_out_disable_i(sdis));
  uart_props uart_props_i (.mclk_i, .resetn_i,
    .tx_clock_16x(link_a.tx_clock_16x), .master_reset_i(mr),
    .tx_buffer_load_n_i(load_n), .rx_output_disable_i(rdis),
    .status_out_disable_i(sdis), .serial_tx_out_o(tx_out),
    .tx_buffer_empty_o(tbe), .tx_buffer_empty_oe_n_o(tbe_oe),
    .tx_shift_empty_o(tx_shift_empty), .rx_char_out_oe_n_o(a_roe),
    .status_oe_n_o(a_soe), .rx_char_ready_o(a_dr),
    .parity_error_flag_o(a_pe), .framing_error_flag_o(a_fe),
    .overrun_flag_o(a_ov));

  task end_sim;
    if (num_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(string s, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask

  task clk(int n);
    repeat (n) @(negedge mclk_i);
  endtask

  // same format word at both ends
  task fmt(logic [4:0] f);
    ufmt = f;
    ugo = 1'b1;
    bfmt = f;
    bload = 1'b1;
    clk(1);
    ugo = 1'b0;
    bload = 1'b0;
    clk(6);
  endtask

  task clr;
    clr_n = 1'b0;
    clk(1);
    clr_n = 1'b1;
    clk(1);
    chk("dr", 0, dr);
  endtask

  task push(logic [7:0] d);
    udata = d;
    uvalid = 1'b1;
    while (uready !== 1'b1) begin
      full = 1'b1;
      clk(1);
    end
    clk(1);
    uvalid = 1'b0;
    clk(1);
  endtask

  task idle;
    for (int i = 0; i < 300 && tx_shift_empty !== 1'b1; i++) clk(1);
    chk("tre", 1, tx_shift_empty);
  endtask

  // one frame on the wire, bit fb flipped toward the far end
  task frame(logic [4:0] f, logic [7:0] d, int fb);
    int n;
    int nb;
    logic [7:0] m;
    logic [11:0] b;
    n = 5 + int'(f[1:0]);
    m = d & (8'hff >> (8 - n));
    b = 12'hfff;
    b[0] = 1'b0;
    for (int i = 0; i < n; i++) b[i + 1] = m[i];
    nb = n + 1;
    if (!f[4]) begin
      b[nb] = ^m ^ ~f[3];
      nb++;
    end
    nb++;
    do clk(1); while (tx_out !== 1'b0);
    tp = tf;
    tf = $time;
    clk(16);
    for (int k = 0; k < nb; k++) begin
      chk("line", b[k], tx_out);
      if (k < nb - 1) begin
        clk(24);
        flip = (k + 1 == fb);
        clk(8);
      end
    end
    chk("tre", 0, tx_shift_empty);
    clk(12);
    flip = 1'b0;
    chk("rx", m, rx);
    chk("dr", 1, dr);
    chk("pe", !f[4] && fb == n + 1, pe);
    chk("fe", fb == nb - 1, fe);
    chk("ov", ovx, ov);
  endtask

  initial begin
    clk(12);
    resetn_i = 1'b1;
    clk(2);
    mr = 1'b1;
    clk(2);
    chk("tbe", 1, tbe);
    chk("tre", 0, tx_shift_empty);
    mr = 1'b0;
    clk(17);
    chk("tre", 1, tx_shift_empty);
    for (int v = 1; v >= 0; v--) begin
      rdis = v[0];
      sdis = v[0];
      clk(2);
      chk("roe", v[0], roe);
      chk("soe", v[0], soe);
      chk("toe", v[0], tbe_oe);
    end
    for (int i = 0; i < 9; i++) begin
      fmt(cf[i]);
      clr();
      push(cd[i]);
      frame(cf[i], cd[i], cb[i]);
      clk(12);
      if (cf[i][2] && cf[i][1:0] != 2'h0) chk("stop2", 0, tx_shift_empty);
      idle();
    end
    fmt(5'h1b);
    chk("pe", 0, pe);
    fmt(5'h0b);
    clr();
    fork
      for (int i = 0; i < 9; i++) push(8'h30 + 8'(i));
      for (int i = 0; i < 9; i++) begin
        ovx = (i > 0);
        frame(5'h0b, 8'h30 + 8'(i), -1);
        if (i > 0) chk("gap", 352, 16'((tf - tp) / 10));
      end
    join
    chk("full", 1, full);
    idle();
    clr();
    ovx = 1'b0;
    push(8'h11);
    frame(5'h0b, 8'h11, -1);
    idle();
    end_sim();
  end

  initial begin
    clk(40000);
    num_errors++;
    end_sim();
  end
endmodule // pin_programmed_async_uart_test

// [testbench/uart_props.sv]
module uart_props (
  // clock, reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // link and control
  input wire logic tx_clock_16x,
  input wire logic master_reset_i,
  input wire logic tx_buffer_load_n_i,
  input wire logic rx_output_disable_i,
  input wire logic status_out_disable_i,
  // transmit side
  input wire logic serial_tx_out_o,
  input wire logic tx_buffer_empty_o,
  input wire logic tx_buffer_empty_oe_n_o,
  input wire logic tx_shift_empty_o,
  // receive side
  input wire logic rx_char_out_oe_n_o,
  input wire logic status_oe_n_o,
  input wire logic rx_char_ready_o,
  input wire logic parity_error_flag_o,
  input wire logic framing_error_flag_o,
  input wire logic overrun_flag_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  chk_mr_clears: assert property (
    master_reset_i |=> !parity_error_flag_o && !framing_error_flag_o
      && !overrun_flag_o && !rx_char_ready_o && tx_buffer_empty_o
      && serial_tx_out_o && !tx_shift_empty_o)
    else $error("master reset left a flag wrong");
  chk_tre_return: assert property (
    $fell(master_reset_i) |-> ##[0:17] tx_shift_empty_o)
    else $error("shift empty late after master reset");
  chk_rx_float: assert property (
    1'b1 |=> rx_char_out_oe_n_o == $past(rx_output_disable_i))
    else $error("char output enable wrong");
  chk_status_float: assert property (
    1'b1 |=> status_oe_n_o == $past(status_out_disable_i)
      && tx_buffer_empty_oe_n_o == $past(status_out_disable_i))
    else $error("status output enable wrong");
  chk_idle_line: assert property (
    tx_buffer_empty_o && tx_shift_empty_o |-> serial_tx_out_o)
    else $error("line not high while idle");
  chk_start_hold: assert property (
    $fell(serial_tx_out_o) |-> (!serial_tx_out_o) [*8])
    else $error("start bit too short");
  chk_load_busy: assert property (
    !tx_buffer_load_n_i |=> !tx_buffer_empty_o)
    else $error("buffer empty stayed high on load");
  chk_tbe_move: assert property (
    $rose(tx_buffer_empty_o) |-> $fell(serial_tx_out_o)
      || $past(master_reset_i))
    else $error("buffer empty rose without a move");
  chk_load_pulse: assert property (
    $fell(tx_buffer_load_n_i) |=> tx_buffer_load_n_i ##1 tx_buffer_load_n_i)
    else $error("load pulse not one cycle");
  chk_tick_half: assert property (
    $rose(tx_clock_16x) |-> ##[1:256] $fell(tx_clock_16x))
    else $error("tick clock stuck high");
endmodule // uart_props
